/* verilog/supervisor_pkg.sv */
// Purpose: Shared constants and carriers for the supply supervisor control
// Assumes: 100 MHz system clock, Avalon-MM register slave with 32-bit data
// Notes: Byte offsets; printed offset 0x55 is kept as an index, address x4
package supervisor_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TURN_ON_DELAY_US = 50;
  localparam int unsigned LEVEL_CHANGE_DELAY_US = 12;
  // Least time rounds up, longest rounds down; both exact at 100 MHz
  localparam int unsigned TURN_ON_CYCLES = TURN_ON_DELAY_US * CLK_MHZ;
  localparam int unsigned LEVEL_CHANGE_CYCLES =
    LEVEL_CHANGE_DELAY_US * CLK_MHZ;
  localparam int unsigned DELAY_W = 16;

  localparam logic [7:0] CONTROL_INDEX = 8'h55;
  localparam logic [9:0] CONTROL_ADDR = 10'h154;
  localparam logic [9:0] IRQ_STATUS_ADDR = 10'h160;
  localparam logic [9:0] IRQ_CLEAR_ADDR = 10'h164;
  localparam logic [9:0] IRQ_ENABLE_ADDR = 10'h168;

  localparam int unsigned LEVEL_MSB = 7;
  localparam int unsigned LEVEL_LSB = 4;
  localparam int unsigned RESET_EN_BIT = 3;
  localparam int unsigned ACTIVE_BIT = 2;
  localparam int unsigned COMP_BIT = 1;
  localparam int unsigned FLAG_BIT = 0;

  localparam logic [3:0] LEVEL_OFF = 4'h0;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Interrupt status bit positions
  localparam int unsigned EV_LOW = 0;
  localparam int unsigned EV_ACTIVE = 1;
  localparam int unsigned EV_W = 2;
  localparam logic [1:0] EV_RESET = 2'h0;

  typedef enum logic [1:0] {
    SETTLE_IDLE,
    SETTLE_TURN_ON,
    SETTLE_LEVEL,
    SETTLE_MONITOR
  } settle_e;

  typedef struct packed {
    logic [3:0] level_select;
    logic reset_on_low_enable;
    logic low_voltage_flag;
  } control_s;

  typedef struct packed {
    logic [3:0] level_select;
    logic use_external;
    logic monitor_active;
  } analog_s;

endpackage : supervisor_pkg

/* verilog/sense_sync.sv */
// Purpose: Two-flop synchroniser for the comparator output
// Assumes: Input is asynchronous to sys_clk
// Notes: First stage is read only by the second stage
module sense_sync
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_s;

  sync_state_s state_q;
  sync_state_s state_d;

  always_comb
  begin
    state_d.meta = async_in;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.sync;

endmodule : sense_sync

/* verilog/supply_supervisor_control.sv */
// Purpose: Control register, settling timer and low-voltage flag logic
// Assumes: rst is the brownout reset; soft and power-on resets are inputs
// Notes: Comparator output high means the watched voltage is low

module supply_supervisor_control
#(
  parameter int unsigned TURN_ON_CYCLES = supervisor_pkg::TURN_ON_CYCLES,
  parameter int unsigned LEVEL_CHANGE_CYCLES =
    supervisor_pkg::LEVEL_CHANGE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_reset_event,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic comparator_out,
  output supervisor_pkg::analog_s analog_ctrl,
  output logic power_on_reset_req,
  output logic irq
);

  typedef struct packed {
    supervisor_pkg::control_s ctrl;
    supervisor_pkg::settle_e settle;
    logic [supervisor_pkg::DELAY_W-1:0] count;
    logic comp;
    logic [supervisor_pkg::EV_W-1:0] irq_status;
    logic [supervisor_pkg::EV_W-1:0] irq_enable;
    logic done;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic por;
    logic irq;
    supervisor_pkg::analog_s analog;
  } state_s;

  state_s q;
  state_s d;
  logic comp_sync;

  function automatic logic is_on(input logic [3:0] level);
    is_on = (level != supervisor_pkg::LEVEL_OFF);
  endfunction : is_on

  function automatic logic is_mapped(input logic [9:0] addr);
    is_mapped = (addr == supervisor_pkg::CONTROL_ADDR) ||
      (addr == supervisor_pkg::IRQ_STATUS_ADDR) ||
      (addr == supervisor_pkg::IRQ_CLEAR_ADDR) ||
      (addr == supervisor_pkg::IRQ_ENABLE_ADDR);
  endfunction : is_mapped

  sense_sync u_sense_sync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(comparator_out),
    .sync_out(comp_sync)
  );

  logic access;
  logic commit;
  logic wr_ctrl;
  logic [3:0] new_level;
  logic active;
  logic low_seen;
  logic flag_rise;
  logic [supervisor_pkg::EV_W-1:0] events;
  logic [7:0] ctrl_view;

  always_comb
  begin
    d = q;
    access = (avs_read || avs_write) && !q.done;
    // Writes land at the answer edge, when the master sees waitrequest low
    commit = avs_write && avs_byteenable[0] && q.done;
    wr_ctrl = commit && (avs_address == supervisor_pkg::CONTROL_ADDR);
    new_level = avs_writedata[supervisor_pkg::LEVEL_MSB:
      supervisor_pkg::LEVEL_LSB];
    d.comp = comp_sync;
    active = (q.settle == supervisor_pkg::SETTLE_MONITOR);
    low_seen = active && q.comp;
    events = '0;

    // Settling timer
    case (q.settle)
      supervisor_pkg::SETTLE_IDLE:
      begin
        d.count = '0;
      end
      supervisor_pkg::SETTLE_TURN_ON, supervisor_pkg::SETTLE_LEVEL:
      begin
        if (q.count <= 16'h0001)
        begin
          d.settle = supervisor_pkg::SETTLE_MONITOR;
          d.count = '0;
          events[supervisor_pkg::EV_ACTIVE] = 1'b1;
        end
        else
        begin
          d.count = q.count - 16'h0001;
        end
      end
      supervisor_pkg::SETTLE_MONITOR:
      begin
        d.count = '0;
      end
      default:
      begin
        d.settle = supervisor_pkg::SETTLE_IDLE;
        d.count = '0;
      end
    endcase

    // Control register write; bits 2 and 1 are never stored
    if (wr_ctrl)
    begin
      d.ctrl.reset_on_low_enable =
        avs_writedata[supervisor_pkg::RESET_EN_BIT];
      d.ctrl.low_voltage_flag = avs_writedata[supervisor_pkg::FLAG_BIT];
      d.ctrl.level_select = new_level;
      if (!is_on(new_level))
      begin
        d.settle = supervisor_pkg::SETTLE_IDLE;
        d.count = '0;
      end
      else if (!is_on(q.ctrl.level_select))
      begin
        d.settle = supervisor_pkg::SETTLE_TURN_ON;
        d.count = TURN_ON_CYCLES[supervisor_pkg::DELAY_W-1:0];
      end
      else if (new_level != q.ctrl.level_select)
      begin
        d.settle = supervisor_pkg::SETTLE_LEVEL;
        d.count = LEVEL_CHANGE_CYCLES[supervisor_pkg::DELAY_W-1:0];
      end
    end

    // Set wins over a software clear while the condition persists
    if (low_seen)
    begin
      d.ctrl.low_voltage_flag = 1'b1;
    end
    flag_rise = d.ctrl.low_voltage_flag && !q.ctrl.low_voltage_flag;
    if (low_seen && flag_rise)
    begin
      events[supervisor_pkg::EV_LOW] = 1'b1;
    end
    // Reset request only on a hardware set, never during settling
    d.por = low_seen && flag_rise &&
      q.ctrl.reset_on_low_enable;

    // Interrupt status: write-one-to-clear, set wins; enable is a plain write
    if (commit)
    begin
      if (avs_address == supervisor_pkg::IRQ_CLEAR_ADDR)
      begin
        d.irq_status = q.irq_status & ~avs_writedata[1:0];
      end
      if (avs_address == supervisor_pkg::IRQ_ENABLE_ADDR)
      begin
        d.irq_enable = avs_writedata[1:0];
      end
    end
    d.irq_status = d.irq_status | events;
    d.irq = |(d.irq_status & d.irq_enable);

    // Register view; monitor-active held low while settling
    ctrl_view = {q.ctrl.level_select, q.ctrl.reset_on_low_enable,
      active, q.comp, q.ctrl.low_voltage_flag};

    // One wait cycle, then answer
    d.done = access;
    d.resp = 2'h0;
    d.rdata = '0;
    if (access)
    begin
      if (!is_mapped(avs_address))
      begin
        d.resp = 2'h2;
      end
      else if (avs_read)
      begin
        case (avs_address)
          supervisor_pkg::CONTROL_ADDR: d.rdata = {24'h000000, ctrl_view};
          supervisor_pkg::IRQ_STATUS_ADDR:
            d.rdata = {30'h00000000, q.irq_status};
          supervisor_pkg::IRQ_ENABLE_ADDR:
            d.rdata = {30'h00000000, q.irq_enable};
          default: d.rdata = '0;
        endcase
      end
    end

    d.analog.level_select = q.ctrl.level_select;
    d.analog.use_external =
      (q.ctrl.level_select == supervisor_pkg::LEVEL_EXTERNAL);
    d.analog.monitor_active = is_on(q.ctrl.level_select);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // Brownout: everything cleared, supervision off
      q <= '0;
      q.ctrl <= supervisor_pkg::control_s'(6'h00);
      q.settle <= supervisor_pkg::SETTLE_IDLE;
      q.irq_status <= supervisor_pkg::EV_RESET;
      q.irq_enable <= supervisor_pkg::EV_RESET;
    end
    else if (soft_reset_event)
    begin
      // Soft/power-on reset keeps control bits and timer
      q <= d;
      q.done <= 1'b0;
      q.rdata <= '0;
      q.resp <= 2'h0;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = !q.done;
  assign avs_response = q.resp;
  assign analog_ctrl = q.analog;
  assign power_on_reset_req = q.por;
  assign irq = q.irq;

endmodule : supply_supervisor_control

/* testbench/comparator_model.sv */
// Purpose: Analog comparator stand-in for the supervisor
// Assumes: Bench levels mean the watched voltage is low
// Notes: Output stays low while supervision is off
module comparator_model
#(
  parameter int DELAY_NS = 3
)
(
  input wire supervisor_pkg::analog_s analog_ctrl,
  input wire logic supply_low,
  input wire logic sense_low,
  output logic comparator_out
);
  // Delay keeps the output off the clock edge, like a real async pin
  assign #DELAY_NS comparator_out =
    (analog_ctrl.level_select != 4'h0) &&
    (analog_ctrl.use_external ? sense_low : supply_low);
endmodule : comparator_model

/* testbench/supervisor_checker.sv */
// Purpose: Port assertions for the supervisor control block
// Assumes: rst is the only disable
// Notes: Settling is seen at the ports as a quiet reset request
module supervisor_checker
#(
  parameter int unsigned TURN_ON_CYCLES = 20
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_reset_event,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic comparator_out,
  input wire supervisor_pkg::analog_s analog_ctrl,
  input wire logic power_on_reset_req,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest
    && !soft_reset_event |=> !avs_waitrequest) else $error("no answer");
  a_answer_stands: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  a_reset_idle: assert property ($past(rst) |-> avs_waitrequest && !irq
    && !power_on_reset_req) else $error("outputs busy after reset");
  a_off_inactive: assert property (
    analog_ctrl.level_select == 4'h0 |-> !analog_ctrl.monitor_active
    && !power_on_reset_req)
    else $error("active while off");
  a_external_route: assert property (
    analog_ctrl.use_external == (analog_ctrl.level_select == 4'hF))
    else $error("sense routing wrong");
  a_settle_blank: assert property (
    $changed(analog_ctrl.level_select) |=> !power_on_reset_req [*4])
    else $error("reset during settling");
  a_turn_on_time: assert property (
    $rose(analog_ctrl.monitor_active) |=> !power_on_reset_req [*8])
    else $error("reset before turn-on delay");
  a_reset_monitoring: assert property (
    power_on_reset_req |-> analog_ctrl.monitor_active)
    else $error("reset while not monitoring");
endmodule : supervisor_checker
bind supply_supervisor_control supervisor_checker
  #(.TURN_ON_CYCLES(TURN_ON_CYCLES)) u_chk (.*);

/* testbench/tb.sv */
// Purpose: Self-checking bench for the supervisor control block
// Assumes: Settling counts shortened to 20 and 8 cycles
// Notes: Level code drawn from a fixed seed
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TON = 20;
  localparam int TLV = 8;
  localparam logic [9:0] CA = supervisor_pkg::CONTROL_ADDR;
  localparam logic [9:0] IEN = supervisor_pkg::IRQ_ENABLE_ADDR;
  localparam logic [9:0] ICL = supervisor_pkg::IRQ_CLEAR_ADDR;
  logic sys_clk = 0, rst = 1, soft_reset_event = 0, avs_read = 0;
  logic avs_write = 0, supply_low = 0, sense_low = 0;
  logic comparator_out, irq, avs_waitrequest, power_on_reset_req;
  logic [9:0] avs_address = 10'h0;
  logic [3:0] avs_byteenable = 4'hF, code;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [1:0] avs_response, rs;
  supervisor_pkg::analog_s analog_ctrl;
  int errors = 0, check_count = 0, cyc = 0, por_n = 0, t0;
  int seed = 32'h0DE133AB;
  supply_supervisor_control #(.TURN_ON_CYCLES(TON), .LEVEL_CHANGE_CYCLES(TLV))
    dut (.*);
  comparator_model far (.*);
  always #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] ctl(input logic [3:0] lv,
    input logic en, act, cmp, flg);
    return {24'h0, lv, en, act, cmp, flg};
  endfunction : ctl
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e, m);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdchk
  task automatic poll();
    do bus(1'b0, CA, 32'h0); while (rd[2] !== 1'b1);
  endtask : poll
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (power_on_reset_req === 1'b1)
      por_n <= por_n + 1;
    if (cyc == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(CA, 32'h0, '1);
    rdchk(10'h3FC, 32'h0, '1);
    chk({30'h0, rs}, 32'h2);
    bus(1'b1, CA, 32'h04);
    rdchk(CA, 32'h0, '1);
    bus(1'b1, IEN, 32'h2);
    code = 4'h1 + 4'((32'($random(seed)) & 32'h7FFFFFFF) % 14);
    t0 = cyc;
    bus(1'b1, CA, ctl(code, 1, 0, 0, 0));
    rdchk(CA, ctl(code, 1, 0, 0, 0), '1);
    poll();
    chk(32'(cyc - t0 >= TON), 32'h1);
    chk({28'h0, analog_ctrl.level_select}, {28'h0, code});
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, ICL, 32'h3);
    chk({31'h0, irq}, 32'h0);
    supply_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(32'(por_n), 32'h1);
    rdchk(CA, ctl(code, 1, 1, 1, 1), '1);
    chk({31'h0, irq}, 32'h0);
    rdchk(supervisor_pkg::IRQ_STATUS_ADDR, 32'h1, 32'h1);
    bus(1'b1, IEN, 32'h3);
    chk({31'h0, irq}, 32'h1);
    supply_low <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rdchk(CA, ctl(code, 1, 1, 0, 1), '1);
    bus(1'b1, ICL, 32'h3);
    bus(1'b1, CA, ctl(code, 0, 0, 0, 0));
    rdchk(CA, ctl(code, 0, 1, 0, 0), '1);
    chk({31'h0, irq}, 32'h0);
    supply_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    bus(1'b1, CA, ctl(code, 0, 0, 0, 0));
    repeat (4) @(posedge sys_clk);
    rdchk(CA, ctl(code, 0, 1, 1, 1), '1);
    chk(32'(por_n), 32'h1);
    supply_low <= 1'b0;
    sense_low <= 1'b1;
    bus(1'b1, CA, 32'h0);
    for (int i = 1; i < 16; i++)
    begin
      t0 = cyc;
      bus(1'b1, CA, ctl(4'(i), 0, 0, 0, 0));
      rdchk(CA, ctl(4'(i), 0, 0, 0, 0), 32'hFD);
      poll();
      chk(32'(i == 1 || cyc - t0 <= TLV + 8), 32'h1);
      chk({31'h0, rd[1]}, 32'(i == 15));
    end
    // External input still low when switched off, so the flag sets again
    bus(1'b1, CA, 32'h0);
    repeat (2) @(posedge sys_clk);
    rdchk(CA, 32'h01, 32'hF5);
    bus(1'b1, CA, ctl(4'h3, 1, 0, 0, 0));
    soft_reset_event <= 1'b1;
    @(posedge sys_clk);
    soft_reset_event <= 1'b0;
    @(posedge sys_clk);
    rdchk(CA, ctl(4'h3, 1, 0, 0, 0), 32'hFB);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(CA, 32'h0, '1);
    tally_and_finish();
  end
endmodule : tb
